// file: logic/sere_pkg.sv
// Constants and types of the serial EEPROM read engine.
// Assumes a single core clock; bus pins arrive unsynchronised.
package sere_pkg;

  // Byte address width and memory size (2 Kbit density)
  localparam int          SERE_ADDR_W     = 8;
  localparam int          SERE_MEM_DEPTH  = 256;
  // Device type identifier in the upper nibble of the select byte
  localparam logic [3:0]  SERE_DEV_TYPE   = 4'hA;
  // Erased memory content
  localparam logic [7:0]  SERE_ERASED     = 8'hFF;
  // Byte address counter value after reset
  localparam logic [7:0]  SERE_ADDR_RESET = 8'h00;
  // Bits per byte on the wire, index of the last one
  localparam logic [2:0]  SERE_LAST_BIT   = 3'h7;
  // Prefetch buffer depth
  localparam int          SERE_BUF_DEPTH  = 2;

  // Protocol states
  typedef enum logic [3:0] {
    SERE_IDLE,
    SERE_DEV,
    SERE_DEV_CHK,
    SERE_DEV_ACK,
    SERE_ADDR,
    SERE_ADDR_CHK,
    SERE_ADDR_ACK,
    SERE_WAIT,
    SERE_TX,
    SERE_TX_ACKW,
    SERE_TX_ACK,
    SERE_TX_NEXT,
    SERE_NACKED
  } sere_state_t;

endpackage

// file: logic/sere_read_engine.sv
// Two-wire EEPROM slave, read side, oversampled on the core clock.
// Assumes the bus clock is far slower than core_clk and that the
// bus wire level is resolved outside from sda_oe (open drain).
`timescale 1ns/1ps

// Behaviour
// - Reads ignore the write protect input completely.
// - Every byte holds FFh until something loads it.
// - Address counter increments once after each byte output.
// - Select with read bit set is acknowledged, then current byte sent.
// - Dummy write's address byte loads the counter before repeated START.
// - Sequential reads start from current or random address read.
// - Acknowledged output byte is followed by the next address's byte.
// - Counter wraps from top address to zero, output continues.
// - Acknowledge sampled in ninth bit; high stops output, standby waits for STOP.
// - Respond only to type 1010b plus matching chip select bits.
// - STOP after a not-acknowledged byte forces standby.
// - Data sampled on clock rise, changed only while clock is low.
module sere_read_engine
  import sere_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  input  wire logic [2:0]             chip_select_inputs,
  input  wire logic                   write_protect_input,
  input  wire logic                   load_en,
  input  wire logic [SERE_ADDR_W-1:0] load_addr,
  input  wire logic [7:0]             load_data,
  output logic                        standby
);

  logic [1:0]             scl_sync;
  logic [1:0]             sda_sync;
  logic                   scl_s;
  logic                   sda_s;
  logic                   scl_d;
  logic                   sda_d;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_cond;
  logic                   stop_cond;
  sere_state_t            state;
  logic [2:0]             bit_cnt;
  logic [7:0]             rx_byte;
  logic [7:0]             tx_byte;
  logic [SERE_ADDR_W-1:0] addr;
  logic [SERE_ADDR_W-1:0] fetch_addr;
  logic [7:0]             mem [SERE_MEM_DEPTH];
  logic [7:0]             buf_data [SERE_BUF_DEPTH];
  logic                   buf_wptr;
  logic                   buf_rptr;
  logic [1:0]             buf_cnt;
  logic                   fill_valid;
  logic                   fill_ready;
  logic                   drain_valid;
  logic                   drain_ready;
  logic                   flush;
  logic                   sel_match;
  logic                   next_oe;

  // Two-stage synchronisers for the bus pins
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
    end
  end
  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];

  // Previous levels for edge and condition detection
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Bus events
  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

  // Select byte check; protect input plays no part in reads
  assign sel_match = (rx_byte[7:4] == SERE_DEV_TYPE) &&
                     (rx_byte[3:1] == chip_select_inputs);
  assign standby   = (state == SERE_IDLE);

  // Memory: erased at reset, loadable from the user side
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < SERE_MEM_DEPTH; i++) begin
        mem[i] <= SERE_ERASED;
      end
    end else if (load_en) begin
      mem[load_addr] <= load_data;
    end
  end

  // Prefetch buffer: filled from memory, drained by the shifter
  assign fill_valid  = 1'b1;
  assign fill_ready  = (buf_cnt != 2'(SERE_BUF_DEPTH));
  assign drain_valid = (buf_cnt != 2'h0);
  assign drain_ready = scl_fall &&
                       ((state == SERE_DEV_ACK && rx_byte[0]) ||
                        state == SERE_TX_NEXT);
  assign flush       = start_cond ||
                       (state == SERE_ADDR_CHK && scl_fall);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      buf_wptr <= 1'b0;
      buf_rptr <= 1'b0;
      buf_cnt  <= 2'h0;
      for (int i = 0; i < SERE_BUF_DEPTH; i++) begin
        buf_data[i] <= SERE_ERASED;
      end
    end else if (flush) begin
      buf_wptr <= 1'b0;
      buf_rptr <= 1'b0;
      buf_cnt  <= 2'h0;
    end else begin
      if (fill_valid && fill_ready) begin
        buf_data[buf_wptr] <= mem[fetch_addr];
        buf_wptr           <= ~buf_wptr;
      end
      if (drain_valid && drain_ready) begin
        buf_rptr <= ~buf_rptr;
      end
      case ({fill_valid && fill_ready, drain_valid && drain_ready})
        2'b10:   buf_cnt <= buf_cnt + 2'h1;
        2'b01:   buf_cnt <= buf_cnt - 2'h1;
        default: buf_cnt <= buf_cnt;
      endcase
    end
  end

  // Fetch pointer runs ahead of the counter by the buffer fill
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fetch_addr <= SERE_ADDR_RESET;
    end else if (state == SERE_ADDR_CHK && scl_fall && !start_cond) begin
      fetch_addr <= rx_byte;
    end else if (start_cond) begin
      fetch_addr <= addr;
    end else if (fill_ready) begin
      fetch_addr <= fetch_addr + 8'h01;
    end
  end

  // Byte address counter, kept across transactions
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      addr <= SERE_ADDR_RESET;
    end else if (state == SERE_ADDR_CHK && scl_fall && !start_cond) begin
      addr <= rx_byte;
    end else if (state == SERE_TX && scl_rise &&
                 bit_cnt == SERE_LAST_BIT && !start_cond) begin
      addr <= addr + 8'h01;
    end
  end

  // Receive shifter and bit counter
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_byte <= 8'h00;
      bit_cnt <= 3'h0;
    end else if (start_cond) begin
      bit_cnt <= 3'h0;
    end else if (scl_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      if (state == SERE_DEV || state == SERE_ADDR) begin
        rx_byte <= {rx_byte[6:0], sda_s};
      end
    end else if (scl_fall && (state == SERE_DEV_ACK ||
                              state == SERE_TX_NEXT)) begin
      bit_cnt <= 3'h0;
    end
  end

  // Transmit shifter: loads on the fall that starts a byte
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_byte <= SERE_ERASED;
    end else if (drain_valid && drain_ready && !start_cond) begin
      tx_byte <= buf_data[buf_rptr];
    end else if (scl_fall && state == SERE_TX) begin
      tx_byte <= {tx_byte[6:0], 1'b1};
    end
  end

  // Protocol sequencer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= SERE_IDLE;
    end else if (start_cond) begin
      state <= SERE_DEV;
    end else if (stop_cond) begin
      state <= SERE_IDLE;
    end else begin
      case (state)
        SERE_IDLE: state <= SERE_IDLE;
        SERE_DEV: begin
          if (scl_rise && bit_cnt == SERE_LAST_BIT) begin
            state <= SERE_DEV_CHK;
          end
        end
        SERE_DEV_CHK: begin
          if (scl_fall) begin
            state <= sel_match ? SERE_DEV_ACK : SERE_IDLE;
          end
        end
        SERE_DEV_ACK: begin
          if (scl_fall) begin
            state <= rx_byte[0] ? SERE_TX : SERE_ADDR;
          end
        end
        SERE_ADDR: begin
          if (scl_rise && bit_cnt == SERE_LAST_BIT) begin
            state <= SERE_ADDR_CHK;
          end
        end
        SERE_ADDR_CHK: if (scl_fall) state <= SERE_ADDR_ACK;
        SERE_ADDR_ACK: if (scl_fall) state <= SERE_WAIT;
        SERE_WAIT:     state <= SERE_WAIT;
        SERE_TX: begin
          if (scl_rise && bit_cnt == SERE_LAST_BIT) begin
            state <= SERE_TX_ACKW;
          end
        end
        SERE_TX_ACKW: if (scl_fall) state <= SERE_TX_ACK;
        SERE_TX_ACK: begin
          if (scl_rise) begin
            state <= sda_s ? SERE_NACKED : SERE_TX_NEXT;
          end
        end
        SERE_TX_NEXT: if (scl_fall) state <= SERE_TX;
        SERE_NACKED:  state <= SERE_NACKED;
        default:      state <= SERE_IDLE;
      endcase
    end
  end

  // Pull low for ACK and zero bits; last bit held past its rise
  always_comb begin
    case (state)
      SERE_DEV_ACK, SERE_ADDR_ACK: next_oe = 1'b1;
      SERE_TX, SERE_TX_ACKW:       next_oe = ~tx_byte[7];
      default:                     next_oe = 1'b0;
    endcase
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= next_oe;
    end
  end
  assign sda_out = 1'b0;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_addr_inc;
    state == SERE_TX && scl_rise && bit_cnt == SERE_LAST_BIT &&
      !start_cond |=> addr == $past(addr) + 8'h01;
  endproperty
  a_addr_inc: assert property (p_addr_inc)
    else $error("counter did not step after byte");

  property p_wrap;
    state == SERE_TX && scl_rise && bit_cnt == SERE_LAST_BIT &&
      !start_cond && addr == 8'hFF |=> addr == 8'h00 && state == SERE_TX_ACKW;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap to zero");

  property p_nack;
    state == SERE_TX_ACK && scl_rise && sda_s && !start_cond &&
      !stop_cond |=> state == SERE_NACKED ##1 !sda_oe;
  endproperty
  a_nack: assert property (p_nack)
    else $error("output continued after no acknowledge");

  property p_desel;
    state == SERE_DEV_CHK && scl_fall && !sel_match && !start_cond &&
      !stop_cond |=> state == SERE_IDLE ##1 !sda_oe;
  endproperty
  a_desel: assert property (p_desel)
    else $error("foreign select byte answered");

  property p_stop_standby;
    state == SERE_NACKED && stop_cond |=> standby;
  endproperty
  a_stop_standby: assert property (p_stop_standby)
    else $error("stop after no acknowledge missed standby");

  property p_read_sel;
    state == SERE_DEV_ACK && scl_fall && rx_byte[0] && !start_cond &&
      !stop_cond |=> state == SERE_TX && tx_byte == $past(buf_data[buf_rptr]);
  endproperty
  a_read_sel: assert property (p_read_sel)
    else $error("read select did not start output");

  property p_addr_load;
    state == SERE_ADDR_CHK && scl_fall && !start_cond && !stop_cond
      |=> addr == $past(rx_byte) ##1 sda_oe;
  endproperty
  a_addr_load: assert property (p_addr_load)
    else $error("address byte not loaded and acknowledged");

  property p_seq;
    state == SERE_TX_ACK && scl_rise && !sda_s && !start_cond &&
      !stop_cond |=> state == SERE_TX_NEXT;
  endproperty
  a_seq: assert property (p_seq)
    else $error("acknowledge did not continue stream");

  property p_change_low;
    state == SERE_TX && $changed(sda_oe) |-> !scl_s;
  endproperty
  a_change_low: assert property (p_change_low)
    else $error("data changed while clock high");
endmodule

// file: verif/sere_bus_master.sv
// Behavioural two-wire bus master that drives the read engine.
// Assumes an external pull-up: the wire is low only while pulled.
`timescale 1ns/1ps

module sere_bus_master (
  input  wire logic core_clk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_low
);
  localparam int HALF = 10;

  // Bus idles with clock high and data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Wait n core clocks, then step just past the edge
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One bit: change data mid low phase, sample late in high phase
  task automatic bit_io(input logic b, output logic r);
    hold(HALF / 2);
    sda_low = ~b;
    hold(HALF / 2);
    scl = 1'b1;
    hold(HALF);
    r = sda_in;
    scl = 1'b0;
  endtask

  // Start or repeated start: data falls while clock is high
  task automatic start();
    hold(HALF / 2);
    sda_low = 1'b0;
    hold(HALF / 2);
    scl = 1'b1;
    hold(HALF);
    sda_low = 1'b1;
    hold(HALF);
    scl = 1'b0;
  endtask

  // Stop: data rises while clock is high, clock then stands high
  task automatic stop();
    hold(HALF / 2);
    sda_low = 1'b1;
    hold(HALF / 2);
    scl = 1'b1;
    hold(HALF);
    sda_low = 1'b0;
    hold(HALF);
  endtask

  // Send a byte MSB first, return the slave acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Receive a byte, acknowledge it or leave the slot high
  task automatic rd_byte(input logic ack_it, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~ack_it, r);
  endtask
endmodule

// file: verif/sere_read_engine_test.sv
// Self-checking bench of the read engine against a memory model.
// Assumes the bus master model and the design package are compiled.
`timescale 1ns/1ps

module sere_read_engine_test;
  import sere_pkg::*;
  logic       core_clk, resetn, load_en, write_protect_input;
  logic [2:0] chip_select_inputs;
  logic [7:0] load_addr, load_data, d;
  logic       scl, m_low, sda_out, sda_oe, standby, sda, a;
  int         error_cnt, samples_checked, cycles, seed, cnt;
  int         mem [256];

  // Wire level with pull-up, either party may pull low
  assign sda = ~(m_low | sda_oe);

  sere_bus_master M (.core_clk(core_clk), .sda_in(sda), .scl(scl),
                     .sda_low(m_low));

  sere_read_engine DUT (.core_clk(core_clk), .resetn(resetn),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_inputs(chip_select_inputs),
    .write_protect_input(write_protect_input), .load_en(load_en),
    .load_addr(load_addr), .load_data(load_data), .standby(standby));

  // Clock generation
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Preload one byte with random data into design and model
  task automatic preload(input logic [7:0] ad);
    @(posedge core_clk);
    #1;
    load_en = 1'b1;
    load_addr = ad;
    load_data = 8'($random(seed));
    mem[ad] = load_data;
    @(posedge core_clk);
    #1;
    load_en = 1'b0;
  endtask

  // Read n bytes, acknowledging all but the last
  task automatic read_run(input int n);
    for (int i = 0; i < n; i++) begin
      write_protect_input = 1'($random(seed));
      M.rd_byte(i < n - 1, d);
      check("read data", d, mem[cnt][7:0]);
      cnt = (cnt + 1) % 256;
    end
  endtask

  // Select with the given direction, return acknowledge
  task automatic select(input logic rw);
    M.start();
    M.wr_byte({SERE_DEV_TYPE, chip_select_inputs, rw}, a);
  endtask

  task automatic stop_idle();
    M.stop();
    check("standby", {7'h00, standby}, 8'h01);
  endtask

  initial begin
    seed = 32'h36F2;
    resetn = 1'b0;
    load_en = 1'b0;
    load_addr = 8'h00;
    load_data = 8'h00;
    write_protect_input = 1'b0;
    chip_select_inputs = 3'h5;
    cnt = 0;
    foreach (mem[i]) mem[i] = 8'hFF;
    repeat (16) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    M.hold(4);
    // Unwritten byte by current address read after reset
    select(1'b1);
    check("select ack", {7'h00, a}, 8'h01);
    check("active", {7'h00, standby}, 8'h00);
    read_run(1);
    stop_idle();
    // Preload around the top address
    preload(8'hFE);
    preload(8'hFF);
    preload(8'h00);
    preload(8'h01);
    preload(8'h02);
    // Random read from FEh, sequential across the wrap
    select(1'b0);
    check("dummy write ack", {7'h00, a}, 8'h01);
    M.wr_byte(8'hFE, a);
    check("address ack", {7'h00, a}, 8'h01);
    cnt = 8'hFE;
    select(1'b1);
    check("repeat select ack", {7'h00, a}, 8'h01);
    read_run(5);
    stop_idle();
    // Sequential current read continues from the kept counter
    select(1'b1);
    read_run(2);
    // Clock a further byte with no stop: line must stay released
    M.rd_byte(1'b0, d);
    check("released after nack", d, 8'hFF);
    stop_idle();
    select(1'b1);
    read_run(1);
    stop_idle();
    // Wrong device type, then wrong chip select bits
    for (int i = 0; i < 2; i++) begin
      M.start();
      M.wr_byte(i == 0 ? {4'hB, chip_select_inputs, 1'b1}
                       : {SERE_DEV_TYPE, ~chip_select_inputs, 1'b1}, a);
      check("foreign select ack", {7'h00, a}, 8'h00);
      check("deselected", {7'h00, standby}, 8'h01);
      stop_idle();
    end
    // Counter untouched by foreign selects
    select(1'b1);
    read_run(1);
    stop_idle();
    complete_run();
  end
endmodule
